// [hw/mtcp_defs.vh]
// constants for the modbus tcp request handler
`ifndef MTCP_DEFS_VH
`define MTCP_DEFS_VH

`define MTCP_SERVER_PORT   16'd502
`define MTCP_PROTO_ID      16'h0000
`define MTCP_UNIT_ID       8'h00
`define MTCP_HDR_BYTES     9'd7
`define MTCP_HDR_LAST      9'd7
`define MTCP_LEN_AFTER     16'h0006

`define MTCP_FC_RD_HOLD    8'h03
`define MTCP_FC_RD_INPUT   8'h04
`define MTCP_FC_WR_ONE     8'h06
`define MTCP_FC_WR_MULTI   8'h10
`define MTCP_FC_RW_MULTI   8'h17
`define MTCP_FC_ENCAP      8'h2b
`define MTCP_FC_OD_ALL     8'h65
`define MTCP_FC_OD_RECORD  8'h66
`define MTCP_SUB_ENCAP     8'h0d
`define MTCP_SUB_START     8'h55
`define MTCP_SUB_NEXT      8'haa
`define MTCP_ERR_FLAG      8'h80

`define MTCP_EX_NONE       8'h00
`define MTCP_EX_FUNC       8'h01
`define MTCP_EX_VALUE      8'h03

`define MTCP_RD_MAX        16'h007d
`define MTCP_WR_MAX        16'h007b
`define MTCP_RW_WR_MAX     16'h0079
`define MTCP_LEN_FIXED     16'h0006
`define MTCP_LEN_EXC       16'h0003
`define MTCP_LEN_RD_BASE   16'h0003
`define MTCP_LEN_WM_BASE   16'h0007
`define MTCP_LEN_RW_BASE   16'h000b
`define MTCP_LEN_VEN_BASE  16'h0002

`define MTCP_SKIP_WR_ONE   4'd2
`define MTCP_SKIP_WR_MULTI 4'd5
`define MTCP_SKIP_RW_MULTI 4'd9
`define MTCP_FIFO_WIDTH    8
`define MTCP_FIFO_DEPTH    32
`define MTCP_FIFO_AW       5

`endif

// [hw/mtcp_fifo.v]
// request data fifo with registered read data
`timescale 1ns/1ps
module mtcp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wptr_q;
    reg [AW-1:0]    rptr_q;
    reg [AW:0]      cnt_q;
    reg [WIDTH-1:0] dout_q;
    reg             ov_q;
    wire            push;
    wire            load;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign push      = in_valid && in_ready;
    // head moves into the output register whenever it is free or taken
    assign load      = (cnt_q != {(AW+1){1'b0}}) && (!ov_q || out_ready);
    assign out_valid = ov_q;
    assign out_data  = dout_q;

    always @(posedge ref_clk) begin
        if (push) begin
            mem_q[wptr_q] <= in_data;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q <= {AW{1'b0}};
            rptr_q <= {AW{1'b0}};
            cnt_q  <= {(AW+1){1'b0}};
            dout_q <= {WIDTH{1'b0}};
            ov_q   <= 1'b0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (load) begin
                dout_q <= mem_q[rptr_q];
                rptr_q <= rptr_q + 1'b1;
                ov_q   <= 1'b1;
            end else if (out_ready) begin
                ov_q   <= 1'b0;
            end
            if (push && !load) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (load && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // mtcp_fifo

// [hw/mtcp_handler.v]
// modbus tcp server request handler: header check, decode, response build
`timescale 1ns/1ps
`include "mtcp_defs.vh"
module mtcp_handler (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_last,
    input  wire [15:0] rx_port,
    input  wire [7:0]  rx_conn,
    input  wire        conn_close,
    output wire        rx_ready,
    output wire        tx_valid,
    output wire [7:0]  tx_data,
    output wire        tx_last,
    input  wire        tx_ready,
    output wire        app_req,
    output wire        app_we,
    output wire [7:0]  app_fc,
    output wire [15:0] app_addr,
    output wire [15:0] app_wdata,
    output wire [15:0] app_cnt,
    input  wire        app_ack,
    input  wire [15:0] app_rdata,
    input  wire [7:0]  app_exc
);
    localparam S_RX = 4'd0, S_END = 4'd1, S_SKIP = 4'd2, S_WR = 4'd3, S_WACK = 4'd4;
    localparam S_PRE = 4'd5, S_HDR = 4'd6, S_BODY = 4'd7, S_RDW = 4'd8, S_FLUSH = 4'd9;
    localparam K_RD = 2'd0, K_ECHO = 2'd1, K_VEN = 2'd2;

    reg [3:0]  state_q;
    reg [8:0]  cnt_q;
    reg [15:0] tid_q;
    reg [15:0] pid_q;
    reg [15:0] len_q;
    reg [7:0]  uid_q;
    reg [7:0]  fc_q;
    reg [71:0] p_q;
    reg        ovf_q;
    reg        port_ok_q;
    reg [7:0]  conn_q;
    reg [7:0]  owner_q;
    reg        owner_v_q;
    reg [7:0]  exc_q;
    reg [1:0]  kind_q;
    reg [3:0]  skip_q;
    reg [8:0]  wr_cnt_q;
    reg [8:0]  rd_cnt_q;
    reg [15:0] wr_addr_q;
    reg [15:0] rd_addr_q;
    reg [15:0] word_q;
    reg [7:0]  hold_q;
    reg        wph_q;
    reg        odd_q;
    reg [8:0]  bidx_q;
    reg        rx_ready_q;
    reg        tx_valid_q;
    reg [7:0]  tx_data_q;
    reg        tx_last_q;
    reg        app_req_q;
    reg        app_we_q;
    reg [7:0]  app_fc_q;
    reg [15:0] app_addr_q;
    reg [15:0] app_wdata_q;
    reg [15:0] app_cnt_q;

    reg [7:0]  d_exc;
    reg [1:0]  d_kind;
    reg [3:0]  d_skip;
    reg [8:0]  d_wcnt;
    reg [8:0]  d_rcnt;
    reg [15:0] d_waddr;
    reg [15:0] d_cnt;
    reg [15:0] rsp_len;
    reg [7:0]  hdr_byte;
    reg [7:0]  body_byte;

    wire        rx_take = rx_valid && rx_ready_q && (state_q == S_RX);
    wire        fifo_in_ready;
    wire        fifo_ov;
    wire [7:0]  fifo_dout;
    wire        fifo_push = rx_take && (cnt_q > `MTCP_HDR_LAST) && fifo_in_ready;
    wire        pad = odd_q && wph_q && (wr_cnt_q == 9'd1);
    wire        wr_byte_ok = fifo_ov || pad;
    wire        fifo_pop = ((state_q == S_SKIP) && (skip_q != 4'd0)) ||
                           ((state_q == S_WR) && !pad) || (state_q == S_FLUSH);
    wire [7:0]  wr_byte = pad ? 8'h00 : fifo_dout;
    wire        can_emit = !tx_valid_q || tx_ready;
    wire [15:0] f_a   = {p_q[7:0], p_q[15:8]};
    wire [15:0] f_q   = {p_q[23:16], p_q[31:24]};
    wire [15:0] f_bc  = {8'h00, p_q[39:32]};
    wire [15:0] f_wa  = {p_q[39:32], p_q[47:40]};
    wire [15:0] f_wq  = {p_q[55:48], p_q[63:56]};
    wire [15:0] f_bc2 = {8'h00, p_q[71:64]};
    wire [8:0]  dlen  = cnt_q - 9'd8;
    wire        len_ok = (cnt_q > `MTCP_HDR_BYTES) &&
                         (len_q == ({7'h00, cnt_q} - `MTCP_LEN_AFTER));
    wire        conn_ok = !owner_v_q || (owner_q == conn_q);
    // nothing is trailing the data: no crc field is expected or made
    wire        frame_ok = port_ok_q && conn_ok && len_ok &&
                           (pid_q == `MTCP_PROTO_ID) &&
                           (uid_q == `MTCP_UNIT_ID);
    wire [8:0]  body_len = rsp_len[8:0] - 9'd2;
    wire [15:0] proto_id = `MTCP_PROTO_ID;
    wire        hdr_done = (bidx_q == `MTCP_HDR_LAST);
    wire        body_end = (bidx_q == body_len - 9'd1);
    wire        has_exc = (exc_q != `MTCP_EX_NONE);
    wire        word_end = (kind_q == K_RD) ? (bidx_q != 9'd0) && !bidx_q[0] : bidx_q[0];

    assign rx_ready  = rx_ready_q;
    assign tx_valid  = tx_valid_q;
    assign tx_data   = tx_data_q;
    assign tx_last   = tx_last_q;
    assign app_req   = app_req_q;
    assign app_we    = app_we_q;
    assign app_fc    = app_fc_q;
    assign app_addr  = app_addr_q;
    assign app_wdata = app_wdata_q;
    assign app_cnt   = app_cnt_q;

    mtcp_fifo #(
        .WIDTH (`MTCP_FIFO_WIDTH),
        .DEPTH (`MTCP_FIFO_DEPTH),
        .AW    (`MTCP_FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_data),
        .out_valid (fifo_ov),
        .out_ready (fifo_pop),
        .out_data  (fifo_dout)
    );

    // request decode, evaluated while the frame sits in S_END
    always @* begin
        d_exc   = `MTCP_EX_NONE;
        d_kind  = K_RD;
        d_skip  = 4'd0;
        d_wcnt  = 9'd0;
        d_rcnt  = 9'd0;
        d_waddr = 16'h0000;
        d_cnt   = f_q;
        case (fc_q)
            `MTCP_FC_RD_HOLD, `MTCP_FC_RD_INPUT: begin
                d_rcnt = f_q[8:0];
                if (len_q != `MTCP_LEN_FIXED || f_q == 16'h0000 || f_q > `MTCP_RD_MAX)
                    d_exc = `MTCP_EX_VALUE;
            end
            `MTCP_FC_WR_ONE: begin
                d_kind  = K_ECHO;
                d_skip  = `MTCP_SKIP_WR_ONE;
                d_wcnt  = 9'd1;
                d_waddr = f_a;
                d_cnt   = 16'h0001;
                if (len_q != `MTCP_LEN_FIXED)
                    d_exc = `MTCP_EX_VALUE;
            end
            `MTCP_FC_WR_MULTI: begin
                d_kind  = K_ECHO;
                d_skip  = `MTCP_SKIP_WR_MULTI;
                d_wcnt  = f_q[8:0];
                d_waddr = f_a;
                if (f_q == 16'h0000 || f_q > `MTCP_WR_MAX || f_bc != {f_q[14:0], 1'b0} ||
                    len_q != `MTCP_LEN_WM_BASE + f_bc)
                    d_exc = `MTCP_EX_VALUE;
            end
            `MTCP_FC_RW_MULTI: begin
                d_skip  = `MTCP_SKIP_RW_MULTI;
                d_wcnt  = f_wq[8:0];
                d_rcnt  = f_q[8:0];
                d_waddr = f_wa;
                if (f_q == 16'h0000 || f_q > `MTCP_RD_MAX || f_wq == 16'h0000 ||
                    f_wq > `MTCP_RW_WR_MAX || f_bc2 != {f_wq[14:0], 1'b0} ||
                    len_q != `MTCP_LEN_RW_BASE + f_bc2)
                    d_exc = `MTCP_EX_VALUE;
            end
            `MTCP_FC_ENCAP, `MTCP_FC_OD_ALL, `MTCP_FC_OD_RECORD: begin
                d_kind = K_VEN;
                d_wcnt = (dlen + 9'd1) >> 1;
                d_cnt  = {7'h00, dlen};
                if (fc_q == `MTCP_FC_ENCAP ? f_a[15:8] != `MTCP_SUB_ENCAP :
                    (f_a[15:8] != `MTCP_SUB_START && f_a[15:8] != `MTCP_SUB_NEXT))
                    d_exc = `MTCP_EX_FUNC;
            end
            default: d_exc = `MTCP_EX_FUNC;
        endcase
        // staging fifo holds 33 bytes with its output register: longer data cannot be held for the write pass
        if (ovf_q && d_exc == `MTCP_EX_NONE)
            d_exc = `MTCP_EX_VALUE;
    end

    // response header and body bytes
    always @* begin
        if (has_exc)
            rsp_len = `MTCP_LEN_EXC;
        else if (kind_q == K_RD)
            rsp_len = `MTCP_LEN_RD_BASE + {6'h00, rd_cnt_q, 1'b0};
        else if (kind_q == K_ECHO)
            rsp_len = `MTCP_LEN_FIXED;
        else
            rsp_len = `MTCP_LEN_VEN_BASE + {6'h00, rd_cnt_q, 1'b0};
        case (bidx_q[2:0])
            3'd0: hdr_byte = tid_q[15:8];
            3'd1: hdr_byte = tid_q[7:0];
            3'd2: hdr_byte = proto_id[15:8];
            3'd3: hdr_byte = proto_id[7:0];
            3'd4: hdr_byte = rsp_len[15:8];
            3'd5: hdr_byte = rsp_len[7:0];
            3'd6: hdr_byte = `MTCP_UNIT_ID;
            default: hdr_byte = has_exc ? (fc_q | `MTCP_ERR_FLAG) : fc_q;
        endcase
        if (has_exc)
            body_byte = exc_q;
        else if (kind_q == K_ECHO)
            body_byte = p_q[{bidx_q[1:0], 3'b000} +: 8];
        else if (kind_q == K_RD)
            body_byte = (bidx_q == 9'd0) ? {rd_cnt_q[6:0], 1'b0} :
                        (bidx_q[0] ? word_q[15:8] : word_q[7:0]);
        else
            body_byte = bidx_q[0] ? word_q[15:8] : word_q[7:0];
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_RX;     cnt_q <= 9'd0;       tid_q <= 16'h0000;
            pid_q <= 16'h0000;   len_q <= 16'h0000;   uid_q <= 8'h00;
            fc_q <= 8'h00;       p_q <= 72'h0;        ovf_q <= 1'b0;
            port_ok_q <= 1'b0;   conn_q <= 8'h00;     owner_q <= 8'h00;
            owner_v_q <= 1'b0;   exc_q <= 8'h00;      kind_q <= K_RD;
            skip_q <= 4'd0;      wr_cnt_q <= 9'd0;    rd_cnt_q <= 9'd0;
            wr_addr_q <= 16'h0000; rd_addr_q <= 16'h0000; word_q <= 16'h0000;
            hold_q <= 8'h00;     wph_q <= 1'b0;       odd_q <= 1'b0;
            bidx_q <= 9'd0;      rx_ready_q <= 1'b0;  tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;  tx_last_q <= 1'b0;   app_req_q <= 1'b0;
            app_we_q <= 1'b0;    app_fc_q <= 8'h00;   app_addr_q <= 16'h0000;
            app_wdata_q <= 16'h0000; app_cnt_q <= 16'h0000;
        end else begin
            if (tx_valid_q && tx_ready)
                tx_valid_q <= 1'b0;
            if (conn_close)
                owner_v_q <= 1'b0;
            case (state_q)
                S_RX: begin
                    rx_ready_q <= 1'b1;
                    if (rx_take) begin
                        if (cnt_q != 9'h1ff)
                            cnt_q <= cnt_q + 9'd1;
                        case (cnt_q)
                            9'd0: begin
                                tid_q[15:8] <= rx_data;
                                port_ok_q   <= (rx_port == `MTCP_SERVER_PORT);
                                conn_q      <= rx_conn;
                            end
                            9'd1: tid_q[7:0]  <= rx_data;
                            9'd2: pid_q[15:8] <= rx_data;
                            9'd3: pid_q[7:0]  <= rx_data;
                            9'd4: len_q[15:8] <= rx_data;
                            9'd5: len_q[7:0]  <= rx_data;
                            9'd6: uid_q       <= rx_data;
                            9'd7: fc_q        <= rx_data;
                            default: begin
                                if (cnt_q < 9'd17)
                                    p_q[{cnt_q[3:0] - 4'd8, 3'b000} +: 8] <= rx_data;
                                if (!fifo_in_ready)
                                    ovf_q <= 1'b1;
                            end
                        endcase
                        if (rx_last) begin
                            rx_ready_q <= 1'b0;
                            state_q    <= S_END;
                        end
                    end
                end
                S_END: begin
                    bidx_q <= 9'd0;
                    wph_q  <= 1'b0;
                    if (!frame_ok) begin
                        state_q <= S_FLUSH;
                    end else begin
                        owner_q   <= conn_q;
                        owner_v_q <= 1'b1;
                        exc_q     <= d_exc;
                        kind_q    <= d_kind;
                        skip_q    <= d_skip;
                        wr_cnt_q  <= d_wcnt;
                        rd_cnt_q  <= d_rcnt;
                        wr_addr_q <= d_waddr;
                        rd_addr_q <= (d_kind == K_VEN) ? 16'h0000 : f_a;
                        odd_q     <= dlen[0];
                        app_fc_q  <= fc_q;
                        app_cnt_q <= d_cnt;
                        state_q   <= (d_exc != `MTCP_EX_NONE) ? S_HDR : S_SKIP;
                    end
                end
                S_SKIP: begin
                    if (skip_q == 4'd0)
                        state_q <= (wr_cnt_q != 9'd0) ? S_WR : S_PRE;
                    else if (fifo_ov)
                        skip_q <= skip_q - 4'd1;
                end
                S_WR: begin
                    if (wr_byte_ok) begin
                        if (!wph_q) begin
                            hold_q <= wr_byte;
                            wph_q  <= 1'b1;
                        end else begin
                            app_wdata_q <= (kind_q == K_VEN) ? {wr_byte, hold_q} :
                                           {hold_q, wr_byte};
                            app_addr_q  <= wr_addr_q;
                            app_req_q   <= 1'b1;
                            app_we_q    <= 1'b1;
                            wph_q       <= 1'b0;
                            state_q     <= S_WACK;
                        end
                    end
                end
                S_WACK: begin
                    if (app_ack) begin
                        app_req_q <= 1'b0;
                        app_we_q  <= 1'b0;
                        wr_addr_q <= wr_addr_q + 16'h0001;
                        wr_cnt_q  <= wr_cnt_q - 9'd1;
                        if (app_exc != `MTCP_EX_NONE) begin
                            exc_q   <= app_exc;
                            state_q <= S_HDR;
                        end else if (wr_cnt_q != 9'd1) begin
                            state_q <= S_WR;
                        end else begin
                            state_q <= (kind_q == K_ECHO) ? S_HDR : S_PRE;
                        end
                    end
                end
                S_PRE: begin
                    // first access decides the exception before any byte leaves
                    if (!app_req_q) begin
                        app_req_q  <= 1'b1;
                        app_addr_q <= rd_addr_q;
                    end else if (app_ack) begin
                        app_req_q <= 1'b0;
                        rd_addr_q <= rd_addr_q + 16'h0001;
                        if (app_exc != `MTCP_EX_NONE)
                            exc_q <= app_exc;
                        else if (kind_q == K_VEN)
                            rd_cnt_q <= {2'b00, app_rdata[6:0]};
                        else
                            word_q <= app_rdata;
                        state_q <= S_HDR;
                    end
                end
                S_HDR: begin
                    if (can_emit) begin
                        tx_valid_q <= 1'b1;
                        tx_data_q  <= hdr_byte;
                        tx_last_q  <= hdr_done && (body_len == 9'd0);
                        bidx_q     <= hdr_done ? 9'd0 : bidx_q + 9'd1;
                        if (hdr_done) begin
                            if (body_len == 9'd0)
                                state_q <= S_FLUSH;
                            else if (kind_q == K_VEN && !has_exc)
                                state_q <= S_RDW;
                            else
                                state_q <= S_BODY;
                        end
                    end
                end
                S_BODY: begin
                    if (can_emit) begin
                        tx_valid_q <= 1'b1;
                        tx_data_q  <= body_byte;
                        tx_last_q  <= body_end;
                        bidx_q     <= bidx_q + 9'd1;
                        if (body_end)
                            state_q <= S_FLUSH;
                        else if (!has_exc && kind_q != K_ECHO && word_end)
                            state_q <= S_RDW;
                    end
                end
                S_RDW: begin
                    // later read errors cannot be reported once the header is out
                    if (!app_req_q) begin
                        app_req_q  <= 1'b1;
                        app_addr_q <= rd_addr_q;
                    end else if (app_ack) begin
                        app_req_q <= 1'b0;
                        rd_addr_q <= rd_addr_q + 16'h0001;
                        word_q    <= app_rdata;
                        state_q   <= S_BODY;
                    end
                end
                default: begin
                    // intake stays shut until the final response byte is taken
                    if (!fifo_ov && !tx_valid_q) begin
                        cnt_q   <= 9'd0;
                        ovf_q   <= 1'b0;
                        p_q     <= 72'h0;
                        state_q <= S_RX;
                    end
                end
            endcase
        end
    end
endmodule // mtcp_handler

// [testbench/mtcp_app_model.sv]
// register application model answering the access port after a stall
`timescale 1ns/1ps
module mtcp_app_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        app_req,
    input  wire logic [15:0] app_addr,
    input  wire logic [7:0]  exc_val,
    output wire logic        app_ack,
    output wire logic [15:0] app_rdata,
    output wire logic [7:0]  app_exc
);
    logic [1:0] wait_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) wait_q <= 2'h0;
        else wait_q <= (app_req && !app_ack) ? wait_q + 2'h1 : 2'h0;
    end
    // two idle cycles so the handler must hold its request
    assign app_ack   = app_req && (wait_q == 2'h2);
    // off-ack data inverted so stale sampling shows up
    assign app_rdata = app_ack ? (app_addr ^ 16'h5a5a) : ~(app_addr ^ 16'h5a5a);
    assign app_exc   = app_ack ? exc_val : ~exc_val;
endmodule // mtcp_app_model

// [testbench/mtcp_handler_sva.sv]
// assertion checker for the request handler ports
`timescale 1ns/1ps
module mtcp_handler_sva (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        rx_valid,
    input wire logic        rx_last,
    input wire logic [15:0] rx_port,
    input wire logic        rx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_last,
    input wire logic        tx_ready,
    input wire logic        app_req,
    input wire logic        app_ack,
    input wire logic [15:0] app_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_rx_stop: assert property (rx_valid && rx_ready && rx_last |=> !rx_ready)
        else $error("intake not paused after last byte");
    a_tx_excl: assert property (tx_valid |-> !rx_ready)
        else $error("response while request intake open");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte changed while stalled");
    a_last_gap: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("byte sent after final response byte");
    a_port_drop: assert property (rx_valid && rx_ready && rx_last && rx_port != 16'h01f6
        |=> !tx_valid [*8])
        else $error("answer given to frame on wrong port");
    a_req_hold: assert property (app_req && !app_ack |=> app_req && $stable(app_addr))
        else $error("access request dropped before ack");
    a_req_fall: assert property (app_req && app_ack |=> !app_req)
        else $error("access request held after ack");
    a_req_late: assert property (app_req |-> !rx_ready)
        else $error("access issued before frame complete");
endmodule // mtcp_handler_sva

bind mtcp_handler mtcp_handler_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_port(rx_port), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .app_req(app_req), .app_ack(app_ack), .app_addr(app_addr));

// [testbench/test_modbus_tcp_request_handler.sv]
// self-checking bench for the request handler
`timescale 1ns/1ps
module test_modbus_tcp_request_handler;
    logic ref_clk = 0, rst_n = 0, rx_valid = 0, rx_last = 0, tx_ready = 0, cclose = 0;
    logic [7:0] rx_data = 8'h00, ex_v = 8'h00, conn = 8'h01;
    logic [32:0] acc = 0;
    integer last_pos = 0;
    logic [15:0] rx_port = 16'h01f6;
    wire rx_ready, tx_valid, tx_last, app_req, app_we, app_ack;
    wire [7:0] tx_data, app_fc, app_exc;
    wire [15:0] app_addr, app_wdata, app_cnt, app_rdata;
    logic [7:0] rq[$];
    integer err_count = 0, check_count = 0;
    mtcp_handler dut (.ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_port(rx_port), .rx_conn(conn),
        .conn_close(cclose), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .app_req(app_req), .app_we(app_we),
        .app_fc(app_fc), .app_addr(app_addr), .app_wdata(app_wdata), .app_cnt(app_cnt),
        .app_ack(app_ack), .app_rdata(app_rdata), .app_exc(app_exc));
    mtcp_app_model u_app (.ref_clk(ref_clk), .rst_n(rst_n), .app_req(app_req),
        .app_addr(app_addr), .exc_val(ex_v), .app_ack(app_ack), .app_rdata(app_rdata),
        .app_exc(app_exc));
    initial forever #12.5 ref_clk = ~ref_clk;
    // sink stalls every other cycle
    always @(negedge ref_clk) tx_ready <= ~tx_ready;
    always @(posedge ref_clk) begin
        if (tx_valid && tx_ready) begin
            rq.push_back(tx_data);
            if (tx_last) last_pos = rq.size();
        end
    end
    // last completed access: direction, address, write word
    always @(posedge ref_clk) if (app_req && app_ack) acc <= {app_we, app_addr, app_wdata};
    task print_verdict;
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // send n request bytes, expect m response bytes (0 means dropped)
    // callers raise the transaction id on every frame
    task xfer(input [103:0] q, input [103:0] e, input integer n, input integer m,
              input [15:0] port);
        integer i;
        rq.delete();
        last_pos = 0;
        rx_port = port;
        for (i = 0; i < n; i++) begin
            @(negedge ref_clk);
            rx_valid = 1;
            rx_data = q[8*(n-1-i) +: 8];
            rx_last = (i == n - 1);
            do @(posedge ref_clk); while (rx_ready !== 1'b1);
        end
        @(negedge ref_clk);
        rx_valid = 0;
        rx_last = 0;
        i = 0;
        while ((m == 0 || rq.size() < m) && i < 300) begin
            @(posedge ref_clk);
            i++;
        end
        @(negedge ref_clk);
        chk(rq.size(), m);
        chk(last_pos, m);
        for (i = 0; i < m && i < rq.size(); i++) chk(rq[i], e[8*(m-1-i) +: 8]);
    endtask
    task t_read;
        xfer(96'h0004_0000_0006_0003_1388_0002, 104'h0004_0000_0007_0003_0449_d249_d3,
             12, 13, 16'h01f6);
        chk(acc[32], 1'b0);
        chk(acc[31:16], 16'h1389);
        chk(app_fc, 8'h03);
        chk(app_cnt, 16'h0002);
    endtask
    task t_read_exc;
        ex_v = 8'h02;
        xfer(96'h0005_0000_0006_0004_0010_0001, 72'h0005_0000_0003_0084_02,
             12, 9, 16'h01f6);
        chk(app_fc, 8'h04);
        ex_v = 8'h00;
    endtask
    task t_bad_code;
        xfer(96'h0006_0000_0006_0005_0000_0001, 72'h0006_0000_0003_0085_01,
             12, 9, 16'h01f6);
    endtask
    task t_zero_count;
        xfer(96'h0007_0000_0006_0003_0000_0000, 72'h0007_0000_0003_0083_03,
             12, 9, 16'h01f6);
    endtask
    task t_write_one;
        xfer(96'h0008_0000_0006_0006_1770_0001, 96'h0008_0000_0006_0006_1770_0001,
             12, 12, 16'h01f6);
        chk(acc[32], 1'b1);
        chk(acc[31:16], 16'h1770);
        chk(acc[15:0], 16'h0001);
        chk(app_fc, 8'h06);
        chk(app_cnt, 16'h0001);
    endtask
    task t_drops;
        xfer(96'h0009_0001_0006_0003_1388_0001, 0, 12, 0, 16'h01f6);
        xfer(96'h000a_0000_0006_0003_1388_0001, 0, 12, 0, 16'h01f7);
        xfer(96'h000b_0000_0006_0103_1388_0001, 0, 12, 0, 16'h01f6);
    endtask
    // second client refused until the owner closes its connection
    task t_conn;
        conn = 8'h02;
        xfer(96'h000c_0000_0006_0005_0000_0001, 0, 12, 0, 16'h01f6);
        @(negedge ref_clk) cclose = 1;
        @(negedge ref_clk) cclose = 0;
        xfer(96'h000d_0000_0006_0005_0000_0001, 72'h000d_0000_0003_0085_01,
             12, 9, 16'h01f6);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1;
        repeat (2) @(posedge ref_clk);
        t_read;
        t_read_exc;
        t_bad_code;
        t_zero_count;
        t_write_one;
        t_drops;
        t_conn;
        print_verdict;
    end
    initial begin
        #500000;
        err_count++;
        print_verdict;
    end
endmodule // test_modbus_tcp_request_handler
